/* verilog/rx_mode_selftest_regs.sv */
`timescale 1ns/100ps
module rx_mode_selftest_regs
  import rx_mode_pkg::*;
(
  // Clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst,
  // AXI4-Lite write
  input  wire logic [rx_mode_pkg::AXI_AW-1:0] i_awaddr,
  input  wire logic                           i_awvalid,
  output logic                                o_awready,
  input  wire logic [rx_mode_pkg::AXI_DW-1:0] i_wdata,
  input  wire logic [3:0]                     i_wstrb,
  input  wire logic                           i_wvalid,
  output logic                                o_wready,
  output logic [1:0]                          o_bresp,
  output logic                                o_bvalid,
  input  wire logic                           i_bready,
  // AXI4-Lite read
  input  wire logic [rx_mode_pkg::AXI_AW-1:0] i_araddr,
  input  wire logic                           i_arvalid,
  output logic                                o_arready,
  output logic [rx_mode_pkg::AXI_DW-1:0]      o_rdata,
  output logic [1:0]                          o_rresp,
  output logic                                o_rvalid,
  input  wire logic                           i_rready,
  // Strap: bit0 fast back channel, bit1 coax, bit2 repeater
  input  wire logic [2:0]                     i_config_strap_pin,
  // Received audio mode codes
  input  wire logic                           i_aux_code_valid,
  input  wire logic [1:0]                     i_aux_audio_mode,
  // Self-test pin configuration and status
  input  wire logic                           i_selftest_pin_en,
  input  wire logic                           i_auto_clock_en,
  input  wire logic                           i_link_port_choice,
  input  wire logic [7:0]                     i_err_count_port0,
  input  wire logic [7:0]                     i_err_count_port1,
  // Back channel and receiver setup
  output logic [1:0]                          o_bc_rate,
  output logic                                o_cable_coax,
  output logic                                o_repeater,
  output logic                                o_audio_auto,
  output logic [1:0]                          o_audio_mode,
  // Self-test controls
  output logic [1:0]                          o_pattern,
  output logic [1:0]                          o_osc_rate,
  output logic                                o_selftest_en,
  output logic [1:0]                          o_selftest_clk_src,
  // Remote serializer write request
  output logic                                o_remote_wr_valid,
  output logic [7:0]                          o_remote_wr_addr,
  output logic [7:0]                          o_remote_wr_data,
  input  wire logic                           i_remote_wr_ready
);
  import rx_mode_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Register images, decoded controls and remote write sequencer
  typedef struct packed {
    logic       rate_sel;
    logic       audio_auto;
    logic       bc_fast;
    logic       coax;
    logic       repeater;
    logic [7:0] selftest;
    logic [1:0] audio_mode;
    logic [1:0] bc_rate;
    logic [1:0] pattern;
    logic [1:0] osc_rate;
    logic       st_en;
    logic       st_en_prev;
    logic [1:0] st_clk_src;
    remote_wr_e rw_state;
    logic [7:0] rw_data;
  } regs_s;

  regs_s st_r;
  regs_s st_nxt;

  // Register-side view of the bus
  logic              wr_en;
  logic [AXI_AW-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              wr_hit;
  logic [AXI_AW-1:0] rd_addr;
  logic [7:0]        rd_data;
  logic              rd_hit;
  // Read image and effective self-test controls
  logic [7:0]        rx_mode_val;
  logic              st_en_cur;
  logic [1:0]        st_src_cur;

  // ----------------------------------------
  // Bus front end
  // ----------------------------------------
  axil_reg_port u_port (
    .i_clk     (i_clk),
    .i_rst     (i_rst),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .o_wr_en   (wr_en),
    .o_wr_addr (wr_addr),
    .o_wr_data (wr_data),
    .i_wr_hit  (wr_hit),
    .o_rd_addr (rd_addr),
    .i_rd_data (rd_data),
    .i_rd_hit  (rd_hit)
  );

  // ----------------------------------------
  // Address decode and read mux
  // ----------------------------------------
  // Status image, reserved bits held at zero
  always_comb begin
    rx_mode_val = '0;
    rx_mode_val[RM_RATE_SEL]   = st_r.rate_sel;
    rx_mode_val[RM_AUDIO_AUTO] = st_r.audio_auto;
    rx_mode_val[RM_BC_FAST]    = st_r.bc_fast;
    rx_mode_val[RM_COAX]       = st_r.coax;
    rx_mode_val[RM_REPEATER]   = st_r.repeater;
  end

  // Write targets; error count is read-only but still answers OKAY
  always_comb begin
    if (wr_addr == ADDR_RX_MODE) begin
      wr_hit = 1'b1;
    end else if (wr_addr == ADDR_SELFTEST) begin
      wr_hit = 1'b1;
    end else if (wr_addr == ADDR_ERR_COUNT) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  // Read data select
  // Unmapped reads answer SLVERR with zero data
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = '0;
    if (rd_addr == ADDR_RX_MODE) begin
      rd_data = rx_mode_val;
    end else if (rd_addr == ADDR_SELFTEST) begin
      rd_data = st_r.selftest;
    end else if (rd_addr == ADDR_ERR_COUNT) begin
      rd_data = i_link_port_choice ? i_err_count_port1 : i_err_count_port0;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // ----------------------------------------
  // Self-test source selection
  // ----------------------------------------
  // Pin or register bits decide enable; clock source always from register
  assign st_en_cur  = st_r.selftest[ST_PIN_CFG] ? i_selftest_pin_en
                                                : st_r.selftest[ST_EN];
  assign st_src_cur = st_r.selftest[ST_CSRC_HI:ST_CSRC_LO];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // Register writes; read-only and reserved bits are never stored
    if (wr_en && (wr_addr == ADDR_RX_MODE)) begin
      st_nxt.rate_sel   = wr_data[RM_RATE_SEL];
      st_nxt.audio_auto = wr_data[RM_AUDIO_AUTO];
      st_nxt.bc_fast    = wr_data[RM_BC_FAST];
      st_nxt.coax       = wr_data[RM_COAX];
    end else if (wr_en && (wr_addr == ADDR_SELFTEST)) begin
      st_nxt.selftest = wr_data;
    end

    // Audio mode follows received codes while autodetect is on
    if (st_r.audio_auto && i_aux_code_valid) begin
      st_nxt.audio_mode = i_aux_audio_mode;
    end

    // Back-channel rate: fast bit overrides the divider choice
    if (st_r.bc_fast) begin
      st_nxt.bc_rate = BC_FAST;
    end else if (st_r.rate_sel) begin
      st_nxt.bc_rate = BC_DIV2;
    end else begin
      st_nxt.bc_rate = BC_DIV4;
    end

    // Output pattern from the upper field bits
    if (st_r.selftest[ST_PAT_HI]) begin
      st_nxt.pattern = PAT_DATA;
    end else if (st_r.selftest[ST_PAT_LO]) begin
      st_nxt.pattern = PAT_ALT;
    end else begin
      st_nxt.pattern = PAT_NONE;
    end

    // Oscillator clock code applies only with auto clock on
    // Reserved code passes through; software must not pick it
    if (i_auto_clock_en) begin
      st_nxt.osc_rate = st_r.selftest[ST_OSC_HI:ST_OSC_LO];
    end else begin
      st_nxt.osc_rate = OSC_50M;
    end

    // Enable history feeds the edge detector below
    st_nxt.st_en      = st_en_cur;
    st_nxt.st_clk_src = st_src_cur;
    st_nxt.st_en_prev = st_en_cur;

    // Remote clock source write on enable rising edge
    case (st_r.rw_state)
      RW_IDLE: begin
        // Edge, not level: a held enable sends one write
        if (st_en_cur && !st_r.st_en_prev) begin
          st_nxt.rw_state = RW_SEND;
          st_nxt.rw_data  = {6'h00, st_src_cur};
        end
      end
      RW_SEND: begin
        // Address and data hold until the far end takes them
        if (i_remote_wr_ready) begin
          st_nxt.rw_state = RW_IDLE;
        end
      end
      default: begin
        st_nxt.rw_state = RW_IDLE;
      end
    endcase

    // Synchronous reset loads strap-derived values
    // Straps are read on every reset, so a late strap still lands
    if (i_rst) begin
      st_nxt            = '0;
      st_nxt.audio_auto = AUDIO_AUTO_RST;
      st_nxt.bc_fast    = i_config_strap_pin[0];
      st_nxt.coax       = i_config_strap_pin[1];
      st_nxt.selftest   = SELFTEST_RST;
      st_nxt.rw_state   = RW_IDLE;
    end
    // Repeater bit tracks the strap only at reset, never by software
    if (i_rst) begin
      st_nxt.repeater = i_config_strap_pin[2];
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Link and receiver setup
  assign o_bc_rate          = st_r.bc_rate;
  assign o_cable_coax       = st_r.coax;
  assign o_repeater         = st_r.repeater;
  assign o_audio_auto       = st_r.audio_auto;
  assign o_audio_mode       = st_r.audio_mode;

  // Self-test controls
  assign o_pattern          = st_r.pattern;
  assign o_osc_rate         = st_r.osc_rate;
  assign o_selftest_en      = st_r.st_en;
  assign o_selftest_clk_src = st_r.st_clk_src;

  // Remote clock source write request
  assign o_remote_wr_valid  = (st_r.rw_state == RW_SEND);
  assign o_remote_wr_addr   = REMOTE_CLK_SRC_REG;
  assign o_remote_wr_data   = st_r.rw_data;

endmodule : rx_mode_selftest_regs

/* verilog/rx_mode_pkg.sv */
package rx_mode_pkg;

  // ----------------------------------------
  // Bus and register map
  // ----------------------------------------
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam logic [7:0] IDX_RX_MODE = 8'h23;  // Printed offsets, used as indices
  localparam logic [7:0] IDX_SELFTEST = 8'h24;
  localparam logic [7:0] IDX_ERR_COUNT = 8'h25;
  localparam logic [AXI_AW-1:0] ADDR_RX_MODE = {IDX_RX_MODE[5:0], 2'b00};
  localparam logic [AXI_AW-1:0] ADDR_SELFTEST = {IDX_SELFTEST[5:0], 2'b00};
  localparam logic [AXI_AW-1:0] ADDR_ERR_COUNT = {IDX_ERR_COUNT[5:0], 2'b00};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [AXI_DW-1:0] DATA_ZERO = 32'h0000_0000;

  // ----------------------------------------
  // Receive mode status field layout
  // ----------------------------------------
  localparam int unsigned RM_RATE_SEL = 6;
  localparam int unsigned RM_AUDIO_AUTO = 5;
  localparam int unsigned RM_BC_FAST = 4;
  localparam int unsigned RM_COAX = 3;
  localparam int unsigned RM_REPEATER = 2;
  localparam logic [7:0] RM_WR_MASK = 8'h78;   // Writable bits 6..3
  localparam logic AUDIO_AUTO_RST = 1'b1;

  // ----------------------------------------
  // Self-test control field layout
  // ----------------------------------------
  localparam int unsigned ST_PAT_HI = 7;
  localparam int unsigned ST_PAT_LO = 6;
  localparam int unsigned ST_OSC_HI = 5;
  localparam int unsigned ST_OSC_LO = 4;
  localparam int unsigned ST_PIN_CFG = 3;
  localparam int unsigned ST_CSRC_HI = 2;
  localparam int unsigned ST_CSRC_LO = 1;
  localparam int unsigned ST_EN = 0;
  localparam logic [7:0] SELFTEST_RST = 8'h08;

  // ----------------------------------------
  // Remote serializer write
  // ----------------------------------------
  localparam logic [7:0] REMOTE_CLK_SRC_REG = 8'h14;
  localparam int unsigned BC_FAST_MBPS = 20;

  // ----------------------------------------
  // Decoded modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    BC_DIV4 = 2'b00,
    BC_DIV2 = 2'b01,
    BC_FAST = 2'b10
  } bc_rate_e;

  typedef enum logic [1:0] {
    PAT_NONE = 2'b00,
    PAT_ALT  = 2'b01,
    PAT_DATA = 2'b10
  } pattern_e;

  typedef enum logic [1:0] {
    OSC_50M  = 2'b00,
    OSC_25M  = 2'b01,
    OSC_10M  = 2'b10,
    OSC_RSVD = 2'b11
  } osc_rate_e;

  typedef enum logic {
    RW_IDLE = 1'b0,
    RW_SEND = 1'b1
  } remote_wr_e;

endpackage : rx_mode_pkg

/* verilog/axil_reg_port.sv */
`timescale 1ns/100ps
module axil_reg_port
  import rx_mode_pkg::*;
(
  // Clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst,
  // AXI4-Lite write
  input  wire logic [rx_mode_pkg::AXI_AW-1:0] i_awaddr,
  input  wire logic                           i_awvalid,
  output logic                                o_awready,
  input  wire logic [rx_mode_pkg::AXI_DW-1:0] i_wdata,
  input  wire logic [3:0]                     i_wstrb,
  input  wire logic                           i_wvalid,
  output logic                                o_wready,
  output logic [1:0]                          o_bresp,
  output logic                                o_bvalid,
  input  wire logic                           i_bready,
  // AXI4-Lite read
  input  wire logic [rx_mode_pkg::AXI_AW-1:0] i_araddr,
  input  wire logic                           i_arvalid,
  output logic                                o_arready,
  output logic [rx_mode_pkg::AXI_DW-1:0]      o_rdata,
  output logic [1:0]                          o_rresp,
  output logic                                o_rvalid,
  input  wire logic                           i_rready,
  // Register side
  output logic                                o_wr_en,
  output logic [rx_mode_pkg::AXI_AW-1:0]      o_wr_addr,
  output logic [7:0]                          o_wr_data,
  input  wire logic                           i_wr_hit,
  output logic [rx_mode_pkg::AXI_AW-1:0]      o_rd_addr,
  input  wire logic [7:0]                     i_rd_data,
  input  wire logic                           i_rd_hit
);
  import rx_mode_pkg::*;

  typedef struct packed {
    logic              have_aw;
    logic              have_w;
    logic [AXI_AW-1:0] awaddr;
    logic [7:0]        wdata;
    logic              wlane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [7:0]        rdata;
  } port_s;

  port_s st_r;
  port_s st_nxt;

  // ----------------------------------------
  // Handshake outputs
  // ----------------------------------------
  assign o_awready = !st_r.have_aw && !st_r.bvalid;
  assign o_wready  = !st_r.have_w && !st_r.bvalid;
  assign o_arready = !st_r.rvalid;
  assign o_bvalid  = st_r.bvalid;
  assign o_bresp   = st_r.bresp;
  assign o_rvalid  = st_r.rvalid;
  assign o_rresp   = st_r.rresp;
  assign o_rdata   = {24'h00_0000, st_r.rdata};
  assign o_rd_addr = i_araddr;
  assign o_wr_addr = st_r.awaddr;
  assign o_wr_data = st_r.wdata;
  // Commit once address and data are both held; only byte lane 0 carries data
  assign o_wr_en   = st_r.have_aw && st_r.have_w && st_r.wlane;

  // Channel tracking
  always_comb begin
    st_nxt = st_r;
    if (o_awready && i_awvalid) begin
      st_nxt.have_aw = 1'b1;
      st_nxt.awaddr  = i_awaddr;
    end
    if (o_wready && i_wvalid) begin
      st_nxt.have_w = 1'b1;
      st_nxt.wdata  = i_wdata[7:0];
      st_nxt.wlane  = i_wstrb[0];
    end
    if (st_r.have_aw && st_r.have_w) begin
      st_nxt.have_aw = 1'b0;
      st_nxt.have_w  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.bresp   = i_wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (st_r.bvalid && i_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.rvalid && i_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (o_arready && i_arvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = i_rd_data;
      st_nxt.rresp  = i_rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : axil_reg_port

/* tb/rx_mode_asserts.sv */
`timescale 1ns/100ps
module rx_mode_asserts
  import rx_mode_pkg::*;
(
  // Clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  // Read side of the bus
  input  wire logic [AXI_AW-1:0] i_araddr,
  input  wire logic              i_arvalid,
  input  wire logic              o_arready,
  input  wire logic [AXI_DW-1:0] o_rdata,
  input  wire logic              o_rvalid,
  // Straps and status inputs
  input  wire logic [2:0]        i_config_strap_pin,
  input  wire logic              i_auto_clock_en,
  input  wire logic              i_link_port_choice,
  input  wire logic [7:0]        i_err_count_port0,
  input  wire logic [7:0]        i_err_count_port1,
  // Decoded controls
  input  wire logic [1:0]        o_bc_rate,
  input  wire logic              o_cable_coax,
  input  wire logic              o_repeater,
  input  wire logic              o_audio_auto,
  input  wire logic [1:0]        o_pattern,
  input  wire logic [1:0]        o_osc_rate,
  input  wire logic              o_selftest_en,
  input  wire logic [1:0]        o_selftest_clk_src,
  // Remote write request
  input  wire logic              o_remote_wr_valid,
  input  wire logic [7:0]        o_remote_wr_addr,
  input  wire logic [7:0]        o_remote_wr_data,
  input  wire logic              i_remote_wr_ready
);
  logic [7:0] err_sel_r;
  logic       ar_err_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // Error count seen at the read address edge
  always_ff @(posedge i_clk) begin
    err_sel_r <= i_link_port_choice ? i_err_count_port1 : i_err_count_port0;
    ar_err_r  <= i_arvalid && o_arready && (i_araddr == ADDR_ERR_COUNT);
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_strap_load: assert property ($fell(i_rst) |-> ##2 (o_repeater == i_config_strap_pin[2]
    && o_cable_coax == i_config_strap_pin[1] && o_audio_auto
    && o_bc_rate == (i_config_strap_pin[0] ? BC_FAST : BC_DIV4)))
    else $error("strap values not loaded at reset");
  a_osc_gated: assert property (!i_auto_clock_en && !$past(i_auto_clock_en)
    |-> o_osc_rate == OSC_50M) else $error("osc rate not gated by auto clock");
  a_rd_upper_zero: assert property (o_rvalid |-> o_rdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_err_count_mux: assert property ($rose(o_rvalid) && ar_err_r
    |-> o_rdata[7:0] == err_sel_r) else $error("wrong port error count");
  a_remote_addr: assert property (o_remote_wr_valid |-> o_remote_wr_addr == 8'h14
    && (!$rose(o_remote_wr_valid) || o_remote_wr_data == {6'h00, o_selftest_clk_src}))
    else $error("remote write address or data wrong");
  a_remote_hold: assert property (o_remote_wr_valid && !i_remote_wr_ready
    |=> o_remote_wr_valid && $stable(o_remote_wr_data)) else $error("remote write dropped");
  a_remote_done: assert property (o_remote_wr_valid && i_remote_wr_ready
    |=> !o_remote_wr_valid) else $error("remote write repeated");
  a_launch_write: assert property ($rose(o_selftest_en) |-> ##[0:2] o_remote_wr_valid)
    else $error("self-test enable sent no remote write");
  a_pattern_code: assert property (o_pattern != 2'b11)
    else $error("illegal pattern code");

  c_remote: cover property ($rose(o_remote_wr_valid));
  c_div2: cover property (o_bc_rate == BC_DIV2);
  c_data_pat: cover property (o_pattern == PAT_DATA);
endmodule : rx_mode_asserts

/* tb/remote_ser_model.sv */
`timescale 1ns/100ps
module remote_ser_model (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  // Write request from the block
  input  wire logic       i_valid,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_data,
  output logic            o_ready,
  // Stall length and acknowledge mode
  input  wire logic [3:0] i_delay,
  input  wire logic       i_auto_ack,
  // Captured clock source and write count
  output logic [7:0]      o_clk_src,
  output logic [7:0]      o_n_wr
);
  logic [3:0] wait_r;
  logic       auto_ack_r;

  // Auto-acknowledge answers at once, else ready once the stall has run out
  assign o_ready = i_valid && (auto_ack_r || (wait_r == i_delay));

  // Stall counter and capture of the clock source write
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_r     <= 4'h0;
      auto_ack_r <= 1'b0;
      o_clk_src  <= 8'h00;
      o_n_wr     <= 8'h00;
    end else begin
      auto_ack_r <= i_auto_ack;
      wait_r     <= (i_valid && !o_ready) ? wait_r + 4'h1 : 4'h0;
      if (o_ready && i_addr == 8'h14) begin
        o_clk_src <= i_data;
        o_n_wr    <= o_n_wr + 8'h01;
      end
    end
  end
endmodule : remote_ser_model

/* tb/tb.sv */
`timescale 1ns/100ps
module tb;
  import rx_mode_pkg::*;
  logic              i_clk, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [AXI_AW-1:0] i_awaddr, i_araddr;
  logic [AXI_DW-1:0] i_wdata, o_rdata;
  logic [3:0]        i_wstrb, dly;
  logic [2:0]        i_config_strap_pin;
  logic              i_aux_code_valid, i_selftest_pin_en, i_auto_clock_en, auto_ack;
  logic              i_link_port_choice, i_remote_wr_ready, o_awready, o_wready;
  logic [1:0]        i_aux_audio_mode, o_bresp, o_rresp, o_bc_rate, o_audio_mode;
  logic [1:0]        o_pattern, o_osc_rate, o_selftest_clk_src;
  logic [7:0]        i_err_count_port0, i_err_count_port1, o_remote_wr_addr;
  logic [7:0]        o_remote_wr_data, src_seen, n_wr;
  logic              o_bvalid, o_arready, o_rvalid, o_cable_coax, o_repeater;
  logic              o_audio_auto, o_selftest_en, o_remote_wr_valid;
  int                n_errors, comparisons, cycles;

  rx_mode_selftest_regs DUT (.*);
  remote_ser_model u_far (.i_clk(i_clk), .i_rst(i_rst), .i_valid(o_remote_wr_valid),
    .i_addr(o_remote_wr_addr), .i_data(o_remote_wr_data), .o_ready(i_remote_wr_ready),
    .i_delay(dly), .i_auto_ack(auto_ack), .o_clk_src(src_seen), .o_n_wr(n_wr));

  // Clock and hang guard
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    i_awaddr <= a;
    i_wdata <= d;
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge i_clk);
      if (i_awvalid && o_awready) aw = 1'b1;
      if (i_wvalid && o_wready) w = 1'b1;
      if (aw) i_awvalid <= 1'b0;
      if (w) i_wvalid <= 1'b0;
    end
    while (o_bvalid !== 1'b1) @(posedge i_clk);
    r = o_bresp;
    i_bready <= 1'b0;
    @(posedge i_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    i_araddr <= a;
    i_arvalid <= 1'b1;
    i_rready <= 1'b1;
    do @(posedge i_clk); while (o_arready !== 1'b1);
    i_arvalid <= 1'b0;
    while (o_rvalid !== 1'b1) @(posedge i_clk);
    d = o_rdata;
    r = o_rresp;
    i_rready <= 1'b0;
    @(posedge i_clk);
  endtask : rd
  task automatic aux(input logic [1:0] m);
    i_aux_audio_mode <= m;
    i_aux_code_valid <= 1'b1;
    @(posedge i_clk);
    i_aux_code_valid <= 1'b0;
    repeat (3) @(posedge i_clk);
  endtask : aux
  task automatic wait_wr(input logic [7:0] n);
    repeat (40) if (n_wr === n) @(posedge i_clk);
    cmp(32'(n_wr), 32'(n + 8'h01));
  endtask : wait_wr

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] d;
    logic [1:0]  r;
    logic [2:0]  s;
    i_rst <= 1'b1;
    repeat (10) @(posedge i_clk);
    s = i_config_strap_pin;
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd(ADDR_RX_MODE, d, r);
    cmp(d, 32'({3'h1, s[0], s[1], s[2], 2'h0}));
    cmp(32'(r), 32'(RESP_OKAY));
    rd(ADDR_SELFTEST, d, r);
    cmp(d, 32'h08);
    cmp(32'(o_bc_rate), s[0] ? 32'(BC_FAST) : 32'(BC_DIV4));
    cmp(32'(o_cable_coax), 32'(s[1]));
    cmp(32'(o_repeater), 32'(s[2]));
  endtask : t_reset
  task automatic t_status();
    logic [7:0]  v [6] = '{8'h20, 8'h60, 8'h70, 8'h08, 8'hFF, 8'h03};
    logic [31:0] d;
    logic [1:0]  r;
    auto_ack <= 1'b1;
    foreach (v[k]) begin
      wr(ADDR_RX_MODE, 32'(v[k]), 4'hF, r);
      cmp(32'(r), 32'(RESP_OKAY));
      rd(ADDR_RX_MODE, d, r);
      cmp(d, 32'(v[k] & RM_WR_MASK | 8'h04));
      cmp(32'(o_bc_rate), v[k][4] ? 32'(BC_FAST) : 32'(v[k][6]));
      cmp(32'(o_cable_coax), 32'(v[k][3]));
    end
  endtask : t_status
  task automatic t_audio();
    logic [1:0] r;
    wr(ADDR_RX_MODE, 32'h20, 4'hF, r);
    aux(2'h2);
    cmp(32'(o_audio_mode), 32'h2);
    wr(ADDR_RX_MODE, 32'h00, 4'hF, r);
    aux(2'h1);
    cmp(32'(o_audio_mode), 32'h2);
    cmp(32'(o_audio_auto), 32'h0);
  endtask : t_audio
  task automatic t_fields();
    logic [31:0] d;
    logic [1:0]  r;
    i_auto_clock_en <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      wr(ADDR_SELFTEST, 32'(k * 16), 4'hF, r);
      rd(ADDR_SELFTEST, d, r);
      cmp(d, 32'(k * 16));
      cmp(32'(o_pattern), k[3] ? 32'(PAT_DATA) : 32'(k[3:2]));
      cmp(32'(o_osc_rate), 32'(k[1:0]));
    end
    i_auto_clock_en <= 1'b0;
    repeat (3) @(posedge i_clk);
    cmp(32'(o_osc_rate), 32'(OSC_50M));
  endtask : t_fields
  task automatic t_launch();
    logic [7:0] n0;
    logic [1:0] r;
    dly <= 4'h3;
    auto_ack <= 1'b0;
    wr(ADDR_SELFTEST, 32'h0C, 4'hF, r);
    n0 = n_wr;
    i_selftest_pin_en <= 1'b1;
    wait_wr(n0);
    cmp(32'(src_seen), 32'h02);
    cmp(32'(o_selftest_en), 32'h1);
    dly <= 4'h0;
    wr(ADDR_SELFTEST, 32'h02, 4'hF, r);
    repeat (4) @(posedge i_clk);
    cmp(32'(o_selftest_en), 32'h0);
    wr(ADDR_SELFTEST, 32'h03, 4'hF, r);
    wait_wr(n0 + 8'h01);
    cmp(32'(src_seen), 32'h01);
    cmp(32'(o_selftest_clk_src), 32'h01);
    i_selftest_pin_en <= 1'b0;
  endtask : t_launch
  task automatic t_err();
    logic [31:0] d;
    logic [1:0]  r;
    i_err_count_port0 <= 8'h5A;
    i_err_count_port1 <= 8'hA5;
    for (int p = 0; p < 2; p++) begin
      i_link_port_choice <= p[0];
      rd(ADDR_ERR_COUNT, d, r);
      cmp(d, p[0] ? 32'hA5 : 32'h5A);
    end
    wr(ADDR_ERR_COUNT, 32'hFF, 4'hF, r);
    cmp(32'(r), 32'(RESP_OKAY));
    rd(ADDR_ERR_COUNT, d, r);
    cmp(d, 32'hA5);
    wr(8'h00, 32'hFF, 4'hF, r);
    cmp(32'(r), 32'(RESP_SLVERR));
    rd(8'h00, d, r);
    cmp(d, DATA_ZERO);
    cmp(32'(r), 32'(RESP_SLVERR));
    wr(ADDR_RX_MODE, 32'h40, 4'h0, r);
    rd(ADDR_RX_MODE, d, r);
    cmp(d, 32'h04);
  endtask : t_err

  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence, reset repeated at the end
  initial begin
    i_rst = 1'b1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, auto_ack} = '0;
    {i_aux_code_valid, i_selftest_pin_en, i_auto_clock_en, i_link_port_choice} = '0;
    {i_awaddr, i_araddr, i_wdata, i_wstrb, dly, i_aux_audio_mode} = '0;
    {i_err_count_port0, i_err_count_port1} = '0;
    i_config_strap_pin = 3'h5;
    t_reset();
    t_status();
    t_audio();
    t_fields();
    t_launch();
    t_err();
    i_config_strap_pin <= 3'h2;
    t_reset();
    tally_and_finish();
  end
endmodule : tb

bind rx_mode_selftest_regs rx_mode_asserts u_chk (.*);
